//--- inc/ceb_pkg.sv
// Shared constants for the conditional-execute and branch decode block
package ceb_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [5:0] CEB_OFS_CTRL   = 6'h00;  // Issue control / status
  localparam logic [5:0] CEB_OFS_INSTR  = 6'h04;  // Instruction word to execute
  localparam logic [5:0] CEB_OFS_PC     = 6'h08;  // Address of current instruction
  localparam logic [5:0] CEB_OFS_FLAGS  = 6'h0c;  // Current status word flags
  localparam logic [5:0] CEB_OFS_LINK   = 6'h10;  // Link register of current bank
  localparam logic [5:0] CEB_OFS_RESULT = 6'h14;  // Class and outcome of last issue
  localparam logic [5:0] CEB_OFS_SCYC   = 6'h18;  // Sequential cycle count
  localparam logic [5:0] CEB_OFS_NCYC   = 6'h1c;  // Nonsequential cycle count
  localparam logic [5:0] CEB_OFS_TARGET = 6'h20;  // Last computed branch target

  // Control register fields
  localparam int CEB_CTRL_ISSUE = 0;  // Write 1: execute the held instruction
  localparam int CEB_CTRL_DONE  = 1;  // Read: an issue has completed since reset

  // Status word flag positions (N, Z, C, V in the top nibble)
  localparam int CEB_FLAG_N = 31;
  localparam int CEB_FLAG_Z = 30;
  localparam int CEB_FLAG_C = 29;
  localparam int CEB_FLAG_V = 28;
  localparam logic [31:0] CEB_FLAGS_MASK = 32'hf0000000;

  // Instruction field positions
  localparam int CEB_COND_HI   = 31;
  localparam int CEB_COND_LO   = 28;
  localparam int CEB_LINK_BIT  = 24;
  localparam int CEB_OFFS_HI   = 23;
  localparam int CEB_OFFS_W    = 24;

  // Condition codes
  localparam logic [3:0] CEB_COND_EQUAL      = 4'h0;  // equal_condition, zero set
  localparam logic [3:0] CEB_COND_UNEQUAL    = 4'h1;  // Zero clear
  localparam logic [3:0] CEB_COND_CARRY      = 4'h2;  // Carry set
  localparam logic [3:0] CEB_COND_NOCARRY    = 4'h3;  // Carry clear
  localparam logic [3:0] CEB_COND_NEG        = 4'h4;  // Negative set
  localparam logic [3:0] CEB_COND_NONNEG     = 4'h5;  // Negative clear
  localparam logic [3:0] CEB_COND_OVF        = 4'h6;  // Overflow set
  localparam logic [3:0] CEB_COND_NOOVF      = 4'h7;  // Overflow clear
  localparam logic [3:0] CEB_COND_ABOVE      = 4'h8;  // Unsigned higher
  localparam logic [3:0] CEB_COND_NOTABOVE   = 4'h9;  // Unsigned lower or same
  localparam logic [3:0] CEB_COND_NOTLESS    = 4'ha;  // Signed greater or equal
  localparam logic [3:0] CEB_COND_LESS       = 4'hb;  // Signed less
  localparam logic [3:0] CEB_COND_GREATER    = 4'hc;  // Signed greater
  localparam logic [3:0] CEB_COND_NOTGREATER = 4'hd;  // Signed less or equal
  localparam logic [3:0] CEB_COND_ALWAYS = 4'he;  // always_condition
  localparam logic [3:0] CEB_COND_NEVER  = 4'hf;  // never_condition

  // Instruction class bit positions in the one-hot class vector
  localparam int CEB_CLS_W     = 11;
  localparam int CEB_CLS_DP    = 0;   // Data processing
  localparam int CEB_CLS_MUL   = 1;   // Multiply
  localparam int CEB_CLS_SWP   = 2;   // Single swap
  localparam int CEB_CLS_SDT   = 3;   // Single transfer
  localparam int CEB_CLS_UND   = 4;   // Undefined
  localparam int CEB_CLS_BDT   = 5;   // Block transfer
  localparam int CEB_CLS_BR    = 6;   // Branch
  localparam int CEB_CLS_CDT   = 7;   // Coprocessor transfer
  localparam int CEB_CLS_CDO   = 8;   // Coprocessor operation
  localparam int CEB_CLS_CRT   = 9;   // Coprocessor register transfer
  localparam int CEB_CLS_SWI   = 10;  // Software interrupt

  // Result register fields
  localparam int CEB_RES_PASS  = 16;  // Condition passed
  localparam int CEB_RES_TAKEN = 17;  // Branch taken
  localparam int CEB_RES_LINK  = 18;  // Link register was written

  // Address arithmetic
  localparam logic [31:0] CEB_WORD_BYTES = 32'h00000004;  // One instruction
  localparam logic [31:0] CEB_PC_AHEAD   = 32'h00000008;  // Prefetch lead

  // Incremental cycle costs
  localparam logic [31:0] CEB_BR_SCYC   = 32'h00000002;  // Taken branch S cycles
  localparam logic [31:0] CEB_BR_NCYC   = 32'h00000001;  // Taken branch N cycles
  localparam logic [31:0] CEB_PLAIN_SCYC = 32'h00000001;  // Any other retire

endpackage

//--- hdl/ceb_cond_eval.sv
// Condition field evaluator against the N, Z, C, V flags
`timescale 1ns/1ps
`default_nettype none
module ceb_cond_eval
  import ceb_pkg::*;
(
  input  wire logic [3:0] cond,      // Condition field of the instruction
  input  wire logic       flagN,     // Negative
  input  wire logic       flagZ,     // Zero
  input  wire logic       flagC,     // Carry
  input  wire logic       flagV,     // Overflow
  output logic            condPass   // Instruction may execute
);

  // One evaluation per code; never_condition treated as false
  always_comb begin
    unique case (cond)
      CEB_COND_EQUAL:      condPass = flagZ;
      CEB_COND_UNEQUAL:    condPass = !flagZ;
      CEB_COND_CARRY:      condPass = flagC;
      CEB_COND_NOCARRY:    condPass = !flagC;
      CEB_COND_NEG:        condPass = flagN;
      CEB_COND_NONNEG:     condPass = !flagN;
      CEB_COND_OVF:        condPass = flagV;
      CEB_COND_NOOVF:      condPass = !flagV;
      CEB_COND_ABOVE:      condPass = flagC && !flagZ;
      CEB_COND_NOTABOVE:   condPass = !flagC || flagZ;
      CEB_COND_NOTLESS:    condPass = (flagN == flagV);
      CEB_COND_LESS:       condPass = (flagN != flagV);
      CEB_COND_GREATER:    condPass = !flagZ && (flagN == flagV);
      CEB_COND_NOTGREATER: condPass = flagZ || (flagN != flagV);
      CEB_COND_ALWAYS: condPass = 1'b1;
      CEB_COND_NEVER:  condPass = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

//--- hdl/ceb_class_decode.sv
// Major instruction class decode from bits 27:24 and 7:4
`timescale 1ns/1ps
`default_nettype none
module ceb_class_decode
  import ceb_pkg::*;
(
  input  wire logic [31:0]          instr,     // Instruction word
  output logic [CEB_CLS_W-1:0]      cls        // One-hot class
);

  logic [3:0] top;   // Bits 27:24
  logic [3:0] low;   // Bits 7:4
  assign top = instr[27:24];
  assign low = instr[7:4];

  // Classification; unallocated patterns fall into the nearest class
  always_comb begin
    cls = '0;
    unique casez (top)
      4'b000?: begin
        // 1001 in bits 7:4 marks multiply (bit 24 low) or swap (bit 24 high)
        if (low == 4'h9 && !top[0]) begin
          cls[CEB_CLS_MUL] = 1'b1;
        end else if (low == 4'h9) begin
          cls[CEB_CLS_SWP] = 1'b1;
        end else begin
          cls[CEB_CLS_DP] = 1'b1;
        end
      end
      4'b001?: cls[CEB_CLS_DP]  = 1'b1;
      4'b010?: cls[CEB_CLS_SDT] = 1'b1;
      4'b011?: begin
        // Register-offset transfer with bit 4 set is undefined
        if (instr[4]) begin
          cls[CEB_CLS_UND] = 1'b1;
        end else begin
          cls[CEB_CLS_SDT] = 1'b1;
        end
      end
      4'b100?: cls[CEB_CLS_BDT] = 1'b1;
      4'b101?: cls[CEB_CLS_BR]  = 1'b1;
      4'b110?: cls[CEB_CLS_CDT] = 1'b1;
      4'b1110: begin
        // Bit 4 splits register transfer from data operation
        if (instr[4]) begin
          cls[CEB_CLS_CRT] = 1'b1;
        end else begin
          cls[CEB_CLS_CDO] = 1'b1;
        end
      end
      4'b1111: cls[CEB_CLS_SWI] = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

//--- hdl/ceb_branch_decode.sv
// Conditional-execute gate, class decode and branch execution unit
// Summary of operation
// - Gate every instruction on condition bits 31:28.
// - Always condition executes regardless of flags.
// - Equal condition executes only with zero set.
// - Branch target: offset shifted, sign extended, added.
// - Program counter used is two words ahead.
// - Link write holds next address; status unsaved.
// - Link bit clear leaves link register alone.
// - Taken branch costs 2S plus 1N.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ceb_branch_decode
  import ceb_pkg::*;
(
  input  wire logic        core_clk,   // Core clock, 20 MHz
  input  wire logic        rst,        // Synchronous reset, active high
  input  wire logic        cyc_i,      // Wishbone cycle
  input  wire logic        stb_i,      // Wishbone strobe
  input  wire logic        we_i,       // Wishbone write enable
  input  wire logic [5:0]  adr_i,      // Wishbone byte address
  input  wire logic [3:0]  sel_i,      // Wishbone byte selects
  input  wire logic [31:0] dat_i,      // Wishbone write data
  output logic      [31:0] dat_o,      // Wishbone read data
  output logic             ack_o,      // Wishbone acknowledge
  output logic             err_o       // Wishbone error, unmapped address
);

  // Software-visible state
  logic [31:0]          instrWord;     // Held instruction word
  logic [31:0]          pcReg;         // Address of the instruction to issue
  logic [31:0]          flagsReg;      // Status word, only NZCV implemented
  logic [31:0]          linkReg;       // Link register of the current bank
  logic [31:0]          sCycles;       // Accumulated sequential cycles
  logic [31:0]          nCycles;       // Accumulated nonsequential cycles
  logic [31:0]          targetReg;     // Last computed branch target
  logic [CEB_CLS_W-1:0] lastClass;     // Class of the last issued word
  logic                 lastPass;      // Condition outcome of last issue
  logic                 lastTaken;     // Last issue was a taken branch
  logic                 lastLinked;    // Last issue wrote the link register
  logic                 issueDone;     // Sticky: an issue has completed

  // Execution pipeline control
  logic                 issuePend;     // One-cycle execute strobe

  // Bus decode
  logic                 busReq;        // New request this cycle
  logic                 busWr;         // Accepted write
  logic                 addrHit;       // Address is mapped
  logic [31:0]          byteMask;      // Byte enables as a bit mask
  logic [31:0]          next_rdata;    // Read data mux

  // Decode results
  logic                 condPass;      // Condition evaluated true
  logic [CEB_CLS_W-1:0] cls;           // One-hot class
  logic                 isBranch;      // Branch class decoded
  logic                 linkBit;       // Branch with link requested
  logic [31:0]          offsExt;       // Shifted, sign-extended offset
  logic [31:0]          pcAhead;       // Prefetch-adjusted program counter
  logic [31:0]          next_target;   // Branch destination
  logic [31:0]          next_seq;      // Address of following instruction

  // A request is new only while no ack is outstanding
  assign busReq   = cyc_i && stb_i && !ack_o && !err_o;
  assign busWr    = busReq && we_i && addrHit;
  assign byteMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Address decode; reads beyond the map raise err_o
  always_comb begin
    addrHit = 1'b1;
    unique case (adr_i)
      CEB_OFS_CTRL, CEB_OFS_INSTR, CEB_OFS_PC, CEB_OFS_FLAGS, CEB_OFS_LINK,
      CEB_OFS_RESULT, CEB_OFS_SCYC, CEB_OFS_NCYC, CEB_OFS_TARGET: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  // Condition gate on the top nibble against N, Z, C, V
  ceb_cond_eval u_cond (
    .cond     (instrWord[CEB_COND_HI:CEB_COND_LO]),
    .flagN    (flagsReg[CEB_FLAG_N]),
    .flagZ    (flagsReg[CEB_FLAG_Z]),
    .flagC    (flagsReg[CEB_FLAG_C]),
    .flagV    (flagsReg[CEB_FLAG_V]),
    .condPass (condPass)
  );

  // Major class of the held word
  ceb_class_decode u_class (
    .instr (instrWord),
    .cls   (cls)
  );

  assign isBranch = cls[CEB_CLS_BR];
  assign linkBit  = instrWord[CEB_LINK_BIT];

  // Offset shifted two places and sign extended to a full word
  assign offsExt = {{6{instrWord[CEB_OFFS_HI]}},
                    instrWord[CEB_OFFS_W-1:0], 2'b00};
  // Program counter seen by the adder leads the branch by two words
  assign pcAhead     = pcReg + CEB_PC_AHEAD;
  assign next_target = pcAhead + offsExt;
  // Following instruction is one word past the branch
  assign next_seq    = pcReg + CEB_WORD_BYTES;

  // Issue strobe: a write of the issue bit executes on the next edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      issuePend <= 1'b0;
    end else begin
      issuePend <= busWr && (adr_i == CEB_OFS_CTRL) && sel_i[0] && dat_i[CEB_CTRL_ISSUE];
    end
  end

  // Instruction word, written by software only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      instrWord <= 32'h00000000;
    end else if (busWr && adr_i == CEB_OFS_INSTR) begin
      instrWord <= (instrWord & ~byteMask) | (dat_i & byteMask);
    end
  end

  // Status flags; execution here never alters them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flagsReg <= 32'h00000000;
    end else if (busWr && adr_i == CEB_OFS_FLAGS) begin
      // Only the NZCV nibble is held, the rest reads zero
      flagsReg <= ((flagsReg & ~byteMask) | (dat_i & byteMask)) & CEB_FLAGS_MASK;
    end
  end

  // Program counter: execution advances it, software may load it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pcReg <= 32'h00000000;
    end else if (issuePend) begin
      if (condPass && isBranch) begin
        pcReg <= next_target;
      end else begin
        // Untaken or non-branch, including a failed condition
        pcReg <= next_seq;
      end
    end else if (busWr && adr_i == CEB_OFS_PC) begin
      pcReg <= (pcReg & ~byteMask) | (dat_i & byteMask);
    end
  end

  // Link register: written by a passing branch with link or by a software load
  always_ff @(posedge core_clk) begin
    if (rst) begin
      linkReg <= 32'h00000000;
    end else if (issuePend && condPass && isBranch && linkBit) begin
      // Status word is deliberately not captured alongside
      linkReg <= next_seq;
    end else if (busWr && adr_i == CEB_OFS_LINK) begin
      // Link bit clear or failed condition falls through here untouched
      linkReg <= (linkReg & ~byteMask) | (dat_i & byteMask);
    end
  end

  // Branch target is recorded for every branch, taken or not
  always_ff @(posedge core_clk) begin
    if (rst) begin
      targetReg <= 32'h00000000;
    end else if (issuePend && isBranch) begin
      targetReg <= next_target;
    end
  end

  // Incremental cycle accounting
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sCycles <= 32'h00000000;
      nCycles <= 32'h00000000;
    end else if (issuePend) begin
      if (condPass && isBranch) begin
        // Refill after a taken branch costs two S and one N
        sCycles <= sCycles + CEB_BR_SCYC;
        nCycles <= nCycles + CEB_BR_NCYC;
      end else begin
        // Skipped or non-branch words cost a single S here
        sCycles <= sCycles + CEB_PLAIN_SCYC;
      end
    end else if (busWr && adr_i == CEB_OFS_SCYC) begin
      // Any write clears the counter
      sCycles <= 32'h00000000;
    end else if (busWr && adr_i == CEB_OFS_NCYC) begin
      nCycles <= 32'h00000000;
    end
  end

  // Outcome of the last issue for software to inspect
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastClass  <= '0;
      lastPass   <= 1'b0;
      lastTaken  <= 1'b0;
      lastLinked <= 1'b0;
      issueDone  <= 1'b0;
    end else if (issuePend) begin
      lastClass  <= cls;
      lastPass   <= condPass;
      lastTaken  <= condPass && isBranch;
      lastLinked <= condPass && isBranch && linkBit;
      issueDone  <= 1'b1;
    end
  end

  // Read data mux; unmapped reads return zero with an error
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (adr_i)
      CEB_OFS_CTRL: begin
        next_rdata[CEB_CTRL_ISSUE] = issuePend;
        next_rdata[CEB_CTRL_DONE]  = issueDone;
      end
      CEB_OFS_INSTR:  next_rdata = instrWord;
      CEB_OFS_PC:     next_rdata = pcReg;
      CEB_OFS_FLAGS:  next_rdata = flagsReg;
      CEB_OFS_LINK:   next_rdata = linkReg;
      CEB_OFS_RESULT: begin
        next_rdata[CEB_CLS_W-1:0]  = lastClass;
        next_rdata[CEB_RES_PASS]   = lastPass;
        next_rdata[CEB_RES_TAKEN]  = lastTaken;
        next_rdata[CEB_RES_LINK]   = lastLinked;
      end
      CEB_OFS_SCYC:   next_rdata = sCycles;
      CEB_OFS_NCYC:   next_rdata = nCycles;
      CEB_OFS_TARGET: next_rdata = targetReg;
      default:        next_rdata = 32'h00000000;
    endcase
  end

  // Registered answer: one cycle after the request, dropped the next
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= busReq && addrHit;
      err_o <= busReq && !addrHit;
      // Data sampled with the request so the master sees a stable word
      dat_o <= (busReq && !we_i) ? next_rdata : 32'h00000000;
    end
  end

endmodule
`default_nettype wire

//--- tb/ceb_branch_decode_asserts.sv
// Bus-side checks for the branch decode block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module ceb_branch_decode_asserts
  import ceb_pkg::*;
(
  input wire logic        core_clk,  // Core clock
  input wire logic        rst,       // Synchronous reset
  input wire logic        cyc_i,     // Bus cycle
  input wire logic        stb_i,     // Bus strobe
  input wire logic        we_i,      // Write direction
  input wire logic [5:0]  adr_i,     // Byte address
  input wire logic [3:0]  sel_i,     // Byte selects
  input wire logic [31:0] dat_i,     // Write data
  input wire logic [31:0] dat_o,     // Read data
  input wire logic        ack_o,     // Acknowledge
  input wire logic        err_o      // Error answer
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // A request is taken only with no answer outstanding
  wire logic req;
  assign req = cyc_i && stb_i && !ack_o && !err_o;

  a_mapped_ack: assert property (req && adr_i[1:0] == 2'b00 && adr_i <= CEB_OFS_TARGET
    |=> ack_o && !err_o) else $error("mapped access not acknowledged");
  a_unmapped_err: assert property (req && adr_i > CEB_OFS_TARGET
    |=> err_o && !ack_o) else $error("unmapped access not refused");
  a_ack_pulse: assert property (ack_o |-> ##1 !ack_o)
    else $error("acknowledge longer than one cycle");
  a_err_pulse: assert property (err_o |=> !err_o)
    else $error("error longer than one cycle");
  a_answer_cause: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
    else $error("answer without request");
  a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside acknowledge");
  a_flags_low: assert property (ack_o && $past(!we_i && adr_i == CEB_OFS_FLAGS)
    |-> dat_o[27:0] == 28'h0) else $error("status word low bits not zero");
  a_class_onehot: assert property (ack_o && $past(!we_i && adr_i == CEB_OFS_RESULT)
    |-> $onehot0(dat_o[10:0])) else $error("class field not one-hot");
  a_result_order: assert property (ack_o && $past(!we_i && adr_i == CEB_OFS_RESULT)
    |-> (!dat_o[17] || dat_o[16]) && (!dat_o[18] || dat_o[17]))
    else $error("taken or link flag without its cause");
endmodule

bind ceb_branch_decode ceb_branch_decode_asserts u_chk (.core_clk(core_clk), .rst(rst),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));
`default_nettype wire

//--- tb/ceb_branch_decode_bench.sv
// Self-checking bench for the branch decode block
`timescale 1ns/1ps
`default_nettype none
module ceb_branch_decode_bench
  import ceb_pkg::*;
;
  logic        core_clk = 1'b0;  // Core clock, 50 ns
  logic        rst;       // Synchronous reset
  logic        cyc;       // Bus cycle
  logic        stb;       // Bus strobe
  logic        we;        // Write direction
  logic [5:0]  adr;       // Byte address
  logic [3:0]  sel;       // Byte selects, whole words only
  logic [31:0] wdat;      // Write data
  logic [31:0] rdat;      // Read data
  logic        ack;       // Acknowledge
  logic        err;       // Error answer
  int          fails;     // Mismatch count
  int          testsRun;  // Comparison count
  logic [31:0] q;         // Data of last access
  logic        e;         // Error seen on last access

  ceb_branch_decode u_dut (.core_clk(core_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .err_o(err));

  // Free-running clock
  always #25 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic bus cycle; answer latency is never assumed
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    // A hang counts as a mismatch and ends the run
    if (n == 20) begin
      fails++;
      report_and_stop();
    end else begin
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // Load an instruction and execute it
  task automatic issue(input logic [31:0] ins);
    wb(1'b1, CEB_OFS_INSTR, ins);
    wb(1'b1, CEB_OFS_CTRL, 32'h1);
  endtask

  // Reference condition table; the never code is treated as false
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    {n, z, cy, v} = f;
    case (c)
      4'h0: return z;
      4'h1: return !z;
      4'h2: return cy;
      4'h3: return !cy;
      4'h4: return n;
      4'h5: return !n;
      4'h6: return v;
      4'h7: return !v;
      4'h8: return cy && !z;
      4'h9: return !cy || z;
      4'ha: return n == v;
      4'hb: return n != v;
      4'hc: return !z && (n == v);
      4'hd: return z || (n != v);
      4'he: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Every register reads zero after reset
  task automatic t_reset();
    for (int i = 0; i <= 8; i++) begin
      wb(1'b0, 6'(i * 4), 32'h0);
      check(q, 32'h0);
    end
    $display("test reset done");
  endtask

  // Every legal condition code against every flag pattern
  task automatic t_cond();
    logic [31:0] pc;
    pc = 32'h0;
    wb(1'b1, CEB_OFS_PC, pc);
    // Software never issues the never condition code
    for (int c = 0; c < 15; c++) begin
      for (int f = 0; f < 16; f++) begin
        wb(1'b1, CEB_OFS_FLAGS, {4'(f), 28'h0});
        issue({4'(c), 28'h1a00000}); // Register move onto itself as no-op
        pc = pc + 32'h4;
        wb(1'b0, CEB_OFS_RESULT, 32'h0);
        check({31'h0, q[CEB_RES_PASS]}, {31'h0, cond_ok(4'(c), 4'(f))});
        wb(1'b0, CEB_OFS_PC, 32'h0);
        check(q, pc);
        wb(1'b0, CEB_OFS_FLAGS, 32'h0);
        check(q, {4'(f), 28'h0});
      end
    end
    $display("test conditions done");
  endtask

  // One branch from a known state, judged on every visible effect but the class field
  task automatic br(input logic [31:0] ins, input logic [31:0] pc0, input logic [3:0] fl);
    logic [31:0] tgt;
    logic        go;
    logic        lnk;
    tgt = pc0 + 32'h8 + {{6{ins[23]}}, ins[23:0], 2'b00};
    go = cond_ok(ins[31:28], fl);
    lnk = go && ins[CEB_LINK_BIT];
    wb(1'b1, CEB_OFS_FLAGS, {fl, 28'h0});
    wb(1'b1, CEB_OFS_PC, pc0);
    wb(1'b1, CEB_OFS_LINK, 32'h5a5a5a5a);
    wb(1'b1, CEB_OFS_SCYC, 32'h0);
    wb(1'b1, CEB_OFS_NCYC, 32'h0);
    issue(ins);
    wb(1'b0, CEB_OFS_PC, 32'h0);
    check(q, go ? tgt : pc0 + 32'h4);
    wb(1'b0, CEB_OFS_LINK, 32'h0);
    check(q, lnk ? pc0 + 32'h4 : 32'h5a5a5a5a);
    wb(1'b0, CEB_OFS_SCYC, 32'h0);
    check(q, go ? 32'h2 : 32'h1);
    wb(1'b0, CEB_OFS_NCYC, 32'h0);
    check(q, {31'h0, go});
    wb(1'b0, CEB_OFS_TARGET, 32'h0);
    check(q, tgt);
    wb(1'b0, CEB_OFS_RESULT, 32'h0);
    check({29'h0, q[18:16]}, {29'h0, lnk, go, go});
    wb(1'b0, CEB_OFS_FLAGS, 32'h0);
    check(q, {fl, 28'h0});
  endtask

  // Offsets at both extremes, self loop, gated and signed-condition links
  task automatic t_branch();
    br(32'hea000010, 32'h00000100, 4'h0);
    br(32'heafffffe, 32'h00000200, 4'h0);
    br(32'heb7fffff, 32'h00001000, 4'h0);
    br(32'heb800000, 32'h04000000, 4'h0);
    br(32'h0b000004, 32'h00000300, 4'h0);
    br(32'h0b000004, 32'h00000300, 4'h4);
    br(32'hbb000001, 32'h00000040, 4'h8);
    $display("test branch done");
  endtask

  // One word of each class; last is an immediate move
  // Stimulus avoids unallocated non-trapping encodings
  task automatic t_class();
    logic [31:0] w [12] = '{32'he1a00000, 32'he0000091, 32'he1000091, 32'he5900000,
      32'he6000010, 32'he8900000, 32'hea000000, 32'hec000000, 32'hee000000,
      32'hee000010, 32'hef000000, 32'he3a00000};
    int k [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 0};
    for (int i = 0; i < 12; i++) begin
      issue(w[i]);
      wb(1'b0, CEB_OFS_RESULT, 32'h0);
      check({21'h0, q[10:0]}, {21'h0, 11'h1 << k[i]});
    end
    $display("test class done");
  endtask

  // Refused address, read-only result, sticky done flag
  task automatic t_bus();
    logic [31:0] keep;
    wb(1'b0, 6'h24, 32'h0);
    check({31'h0, e}, 32'h1);
    wb(1'b0, CEB_OFS_RESULT, 32'h0);
    keep = q;
    wb(1'b1, CEB_OFS_RESULT, 32'hffffffff);
    wb(1'b0, CEB_OFS_RESULT, 32'h0);
    check(q, keep);
    wb(1'b0, CEB_OFS_CTRL, 32'h0);
    check({31'h0, q[CEB_CTRL_DONE]}, 32'h1);
    $display("test bus done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h0;
    sel = 4'hf;
    wdat = 32'h0;
    fails = 0;
    testsRun = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_cond();
    t_branch();
    t_class();
    t_bus();
    report_and_stop();
  end
endmodule
`default_nettype wire
